// file: dj_port_top.sv
// Pin-level data port and mode selection of the rail dejitter block.
//
// How it works
// - Negative output updates on edge-select chosen edge
// - Positive output updates on edge-select chosen edge
// - Edge select from pin or register bit
// - Positive input sampled on edge-select chosen edge
// - Hardware mode: rate pin low DS3, high E3
// - Two address pins give the unit address
// - Output clock nominal rate; launches both rails
// - Bypass high passes rails and clock through
// - Hardware mode: serial interface off, pins configure
`timescale 1ns/100ps
`default_nettype none
module dj_port_top
    import dj_pkg::*;
(
    // System clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // Link clock (recovered line clock)
    input  wire logic        link_clk_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Mode and configuration pins
    input  wire logic        config_mode_select_in,
    input  wire logic        clock_edge_select_in,
    input  wire logic        line_rate_select_in,
    input  wire logic        attenuator_bypass_in,
    input  wire logic        unit_addr_bit1_in,
    input  wire logic        unit_addr_bit0_in,
    // Jittery rails
    input  wire logic        jitter_pos_rail_in,
    input  wire logic        jitter_neg_rail_in,
    // Smoothed rails and clock
    output logic             smooth_pos_rail_out,
    output logic             smooth_neg_rail_out,
    output logic             smooth_clock_out,
    // Status towards the rest of the chip
    output logic             rate_e3_out,
    output logic             serial_access_out,
    output logic      [1:0]  unit_addr_out
);
    // ------------------------------------------------------------------
    // Pin synchronisers into the system domain
    // ------------------------------------------------------------------
    logic [5:0] pins_raw;
    logic [5:0] pins_s;
    logic       host_mode;
    logic       edge_pin;
    logic       rate_pin;
    logic       bypass_pin;
    logic [1:0] addr_pin;

    assign pins_raw = {config_mode_select_in, clock_edge_select_in, line_rate_select_in,
                       attenuator_bypass_in, unit_addr_bit1_in, unit_addr_bit0_in};

    dj_sync #(.WIDTH(6)) u_pin_sync
    (
        .clk_in   (mclk_in),
        .reset_in (reset_in),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign host_mode  = pins_s[5];
    assign edge_pin   = pins_s[4];
    assign rate_pin   = pins_s[3];
    assign bypass_pin = pins_s[2];
    assign addr_pin   = pins_s[1:0];

    // ------------------------------------------------------------------
    // Effective configuration
    // ------------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    dj_cfg_t    cfg_eff;
    logic       sel_n;

    always_comb
    begin
        if (host_mode)
        begin
            cfg_eff.edge_rise = ctrl_q[DJ_CTRL_EDGE_BIT];
            cfg_eff.rate_e3   = ctrl_q[DJ_CTRL_RATE_BIT];
            cfg_eff.bypass    = ctrl_q[DJ_CTRL_BYPASS_BIT];
        end
        else
        begin
            cfg_eff.edge_rise = edge_pin;
            cfg_eff.rate_e3   = rate_pin;
            cfg_eff.bypass    = bypass_pin;
        end
    end

    // The rate pin doubles as the serial select; an undriven pin reads high
    assign sel_n = rate_pin;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    dj_apb_state_t state_q, state_d;
    logic [31:0]   prdata_q, prdata_d;
    logic          pready_q, pready_d;
    logic          pslverr_q, pslverr_d;
    logic          setup;
    logic          commit;
    logic          hit_ctrl;
    logic          hit_stat;
    logic [31:0]   status_word;

    assign setup    = psel_in && !penable_in;
    assign commit   = psel_in && penable_in && pready_q;
    assign hit_ctrl = (paddr_in == DJ_CTRL_OFS);
    assign hit_stat = (paddr_in == DJ_STATUS_OFS);

    always_comb
    begin
        status_word = 32'h0;
        status_word[DJ_STAT_EDGE_BIT]   = cfg_eff.edge_rise;
        status_word[DJ_STAT_RATE_BIT]   = cfg_eff.rate_e3;
        status_word[DJ_STAT_BYPASS_BIT] = cfg_eff.bypass;
        status_word[DJ_STAT_HOST_BIT]   = host_mode;
        status_word[DJ_STAT_SEL_N_BIT]  = sel_n;
        status_word[DJ_STAT_ADDR_LSB+1:DJ_STAT_ADDR_LSB] = addr_pin;
    end

    always_comb
    begin
        state_d   = state_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        ctrl_d    = ctrl_q;
        case (state_q)
            DJ_APB_IDLE:
            begin
                if (setup)
                begin
                    // Zero wait states: answer is ready in the access phase
                    state_d   = DJ_APB_ACCESS;
                    pready_d  = 1'b1;
                    prdata_d  = hit_ctrl ? {29'h0, ctrl_q} : (hit_stat ? status_word : 32'h0);
                    // Register writes are refused while pins own the setup
                    pslverr_d = !(hit_ctrl || hit_stat) || (pwrite_in && (!hit_ctrl || !host_mode));
                end
            end
            DJ_APB_ACCESS:
            begin
                if (commit)
                begin
                    state_d = DJ_APB_IDLE;
                    if (pwrite_in && !pslverr_q)
                    begin
                        ctrl_d = pwdata_in[2:0];
                    end
                end
                else
                begin
                    pready_d  = pready_q;
                    pslverr_d = pslverr_q;
                end
            end
            default:
            begin
                state_d = DJ_APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            state_q   <= DJ_APB_IDLE;
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q    <= DJ_CTRL_RESET;
        end
        else
        begin
            state_q   <= state_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q    <= ctrl_d;
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    logic       rate_q, rate_d;
    logic       serial_q, serial_d;
    logic [1:0] addr_q, addr_d;

    always_comb
    begin
        rate_d   = cfg_eff.rate_e3;
        serial_d = host_mode && !sel_n;
        addr_d   = addr_pin;
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            rate_q   <= 1'b0;
            serial_q <= 1'b0;
            addr_q   <= 2'h0;
        end
        else
        begin
            rate_q   <= rate_d;
            serial_q <= serial_d;
            addr_q   <= addr_d;
        end
    end

    assign rate_e3_out       = rate_q;
    assign serial_access_out = serial_q;
    assign unit_addr_out     = addr_q;

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic     link_reset;
    dj_cfg_t  link_cfg;
    dj_rail_t rail_in;
    dj_rail_t rail_out;

    dj_sync #(.WIDTH(1)) u_reset_sync
    (
        .clk_in   (link_clk_in),
        .reset_in (1'b0),
        .async_in (reset_in),
        .sync_out (link_reset)
    );

    // Settings are static levels, so a plain two-flop crossing suffices
    dj_sync #(.WIDTH(3)) u_cfg_sync
    (
        .clk_in   (link_clk_in),
        .reset_in (link_reset),
        .async_in (cfg_eff),
        .sync_out (link_cfg)
    );

    assign rail_in.pos = jitter_pos_rail_in;
    assign rail_in.neg = jitter_neg_rail_in;

    dj_rail_stage u_rails
    (
        .link_clk_in  (link_clk_in),
        .reset_in     (link_reset),
        .edge_rise_in (link_cfg.edge_rise),
        .bypass_in    (link_cfg.bypass),
        .rail_in      (rail_in),
        .rail_out     (rail_out)
    );

    // The loop that smooths the clock sits outside; the link clock is forwarded
    assign smooth_clock_out    = link_clk_in;
    assign smooth_pos_rail_out = rail_out.pos;
    assign smooth_neg_rail_out = rail_out.neg;

    // Negative rail as it stood at the last falling edge, for the launch check
    logic neg_fall_q;
    logic neg_fall_d;

    always_comb
    begin
        neg_fall_d = rail_out.neg;
    end

    always_ff @(negedge link_clk_in)
    begin
        if (link_reset)
            neg_fall_q <= 1'b0;
        else
            neg_fall_q <= neg_fall_d;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    hw_edge_pin_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !host_mode |-> (cfg_eff.edge_rise == edge_pin))
        else $error("hardware mode edge not from pin");

    host_edge_reg_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        host_mode |-> (cfg_eff.edge_rise == ctrl_q[DJ_CTRL_EDGE_BIT]))
        else $error("host mode edge not from register");

    rate_pin_out_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (!host_mode && $stable(rate_pin)) ##1 !$past(host_mode) |-> (rate_e3_out == $past(rate_pin)))
        else $error("rate output does not follow pin");

    unit_addr_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        ##1 (unit_addr_out == $past(addr_pin)))
        else $error("unit address not taken from pins");

    hw_write_refused_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (setup && pwrite_in && !host_mode) |=> (pslverr_out && pready_out) ##1 $stable(ctrl_q))
        else $error("write accepted in hardware mode");

    serial_select_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (!host_mode || sel_n) |=> !serial_access_out)
        else $error("serial access without host select");

    neg_launch_a: assert property (@(posedge link_clk_in) disable iff (link_reset)
        (link_cfg.edge_rise && $stable(link_cfg)) |-> (smooth_neg_rail_out == neg_fall_q))
        else $error("negative rail moved on falling edge");

endmodule : dj_port_top
`default_nettype wire

// file: dj_pkg.sv
// Package of constants and carrier types for the rail dejitter port.
package dj_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] DJ_CTRL_OFS    = 12'h000;
    localparam logic [11:0] DJ_STATUS_OFS  = 12'h004;

    // Control fields
    localparam int DJ_CTRL_EDGE_BIT   = 0;
    localparam int DJ_CTRL_RATE_BIT   = 1;
    localparam int DJ_CTRL_BYPASS_BIT = 2;
    localparam logic [2:0] DJ_CTRL_RESET = 3'h0;

    // Status fields
    localparam int DJ_STAT_EDGE_BIT   = 0;
    localparam int DJ_STAT_RATE_BIT   = 1;
    localparam int DJ_STAT_BYPASS_BIT = 2;
    localparam int DJ_STAT_HOST_BIT   = 3;
    localparam int DJ_STAT_SEL_N_BIT  = 4;
    localparam int DJ_STAT_ADDR_LSB   = 8;

    // Nominal smoothed clock rates, in kHz
    localparam int DJ_DS3_RATE_KHZ = 44736;
    localparam int DJ_E3_RATE_KHZ  = 34368;

    // Synchroniser depth
    localparam int DJ_SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic bypass;
        logic rate_e3;
        logic edge_rise;
    } dj_cfg_t;

    typedef struct packed
    {
        logic pos;
        logic neg;
    } dj_rail_t;

    typedef enum logic [1:0]
    {
        DJ_APB_IDLE   = 2'b01,
        DJ_APB_ACCESS = 2'b10
    } dj_apb_state_t;

endpackage : dj_pkg

// file: dj_sync.sv
// Two-flop level synchroniser, any width.
`timescale 1ns/100ps
`default_nettype none
module dj_sync
    import dj_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] hold_q;
    logic [WIDTH-1:0] hold_d;

    always_comb
    begin
        meta_d = async_in;
        hold_d = meta_q;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            meta_q <= '0;
            hold_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            hold_q <= hold_d;
        end
    end

    assign sync_out = hold_q;

endmodule : dj_sync
`default_nettype wire

// file: dj_rail_stage.sv
// Rail capture on the selected input edge and launch on the selected output edge.
`timescale 1ns/100ps
`default_nettype none
module dj_rail_stage
    import dj_pkg::*;
(
    // Link clock and reset
    input  wire logic     link_clk_in,
    input  wire logic     reset_in,
    // Settings, already in the link domain
    input  wire logic     edge_rise_in,
    input  wire logic     bypass_in,
    // Rails
    input  wire dj_rail_t rail_in,
    output dj_rail_t      rail_out
);
    dj_rail_t cap_rise_q, cap_rise_d;
    dj_rail_t cap_fall_q, cap_fall_d;
    dj_rail_t hold_q,     hold_d;
    dj_rail_t out_rise_q, out_rise_d;
    dj_rail_t out_fall_q, out_fall_d;
    dj_rail_t sampled;
    dj_rail_t launch;

    always_comb
    begin
        cap_rise_d = rail_in;
        cap_fall_d = rail_in;
        // Edge select high samples on the falling edge, low on the rising
        sampled    = edge_rise_in ? cap_fall_q : cap_rise_q;
        hold_d     = sampled;
        // One stage of retiming stands in for the elastic store when active
        launch     = bypass_in ? sampled : hold_q;
        out_rise_d = launch;
        out_fall_d = launch;
    end

    always_ff @(posedge link_clk_in)
    begin
        if (reset_in)
        begin
            cap_rise_q <= '0;
            hold_q     <= '0;
            out_rise_q <= '0;
        end
        else
        begin
            cap_rise_q <= cap_rise_d;
            hold_q     <= hold_d;
            out_rise_q <= out_rise_d;
        end
    end

    always_ff @(negedge link_clk_in)
    begin
        if (reset_in)
        begin
            cap_fall_q <= '0;
            out_fall_q <= '0;
        end
        else
        begin
            cap_fall_q <= cap_fall_d;
            out_fall_q <= out_fall_d;
        end
    end

    // Both rails leave on the same output clock edge
    assign rail_out = edge_rise_in ? out_rise_q : out_fall_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Rising launch in bypass must carry what the falling edge captured one edge earlier
    rise_launch_a: assert property (@(posedge link_clk_in) disable iff (reset_in)
        (edge_rise_in && bypass_in && $stable(edge_rise_in) && $stable(bypass_in) && !$past(reset_in))
        |-> (rail_out == $past(cap_fall_q)))
        else $error("rail not launched on rising edge");

    fall_capture_a: assert property (@(posedge link_clk_in) disable iff (reset_in)
        (edge_rise_in && $past(edge_rise_in) && !$past(reset_in)) |-> (hold_q == $past(cap_fall_q)))
        else $error("rail not sampled on falling edge");

endmodule : dj_rail_stage
`default_nettype wire

// file: dj_line_model.sv
// Line side partner: recovered clock and jittery rails, with a record of what the port sampled.
`timescale 1ns/100ps
`default_nettype none
module dj_line_model
    import dj_pkg::*;
(
    // Setting the port is expected to use
    input  wire logic edge_rise_in,
    // Line side
    output logic      link_clk_out,
    output dj_rail_t  rail_out,
    // Rails present at the last two sampling edges
    output dj_rail_t  now_out,
    output dj_rail_t  prev_out
);
    logic [7:0] pat_q  = 8'ha5;
    logic       clk_q  = 1'b0;
    dj_rail_t   rail_q = '0;
    dj_rail_t   now_q  = '0;
    dj_rail_t   prev_q = '0;

    assign link_clk_out = clk_q;
    assign rail_out     = rail_q;
    assign now_out      = now_q;
    assign prev_out     = prev_q;

    // Free-running recovered clock, phase unrelated to the system clock
    initial
    begin
        #7;
        forever #24 clk_q = ~clk_q;
    end

    // Rails change only on the edge the port does not sample, so setup and hold are kept
    always @(posedge clk_q or negedge clk_q)
    begin
        if (clk_q ^ edge_rise_in)
        begin
            prev_q <= now_q;
            now_q  <= rail_q;
        end
        else
        begin
            pat_q  <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
            rail_q <= {pat_q[0], pat_q[3]};
        end
    end
endmodule : dj_line_model
`default_nettype wire

// file: dj_port_top_test.sv
// Self-checking bench for the rail dejitter port.
`timescale 1ns/100ps
`default_nettype none
module dj_port_top_test
    import dj_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic        mode = 1'b0;
    logic        edge_pin = 1'b0;
    logic        rate_pin = 1'b0;
    logic        byp_pin = 1'b0;
    logic [1:0]  addr = '0;
    logic        exp_edge = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        link_clk;
    logic        clk_o;
    logic        rate_o;
    logic        acc_o;
    logic [1:0]  addr_o;
    dj_rail_t    rail;
    dj_rail_t    rail_in;
    dj_rail_t    now_r;
    dj_rail_t    prev_r;
    int          failures = 0;
    int          total_checks = 0;

    always #5 mclk_in = ~mclk_in;

    dj_port_top DUT
    (
        .mclk_in(mclk_in), .reset_in(reset_in), .link_clk_in(link_clk),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .config_mode_select_in(mode), .clock_edge_select_in(edge_pin),
        .line_rate_select_in(rate_pin), .attenuator_bypass_in(byp_pin),
        .unit_addr_bit1_in(addr[1]), .unit_addr_bit0_in(addr[0]),
        .jitter_pos_rail_in(rail_in.pos), .jitter_neg_rail_in(rail_in.neg),
        .smooth_pos_rail_out(rail.pos), .smooth_neg_rail_out(rail.neg),
        .smooth_clock_out(clk_o), .rate_e3_out(rate_o), .serial_access_out(acc_o),
        .unit_addr_out(addr_o)
    );

    dj_line_model line
    (
        .edge_rise_in(exp_edge), .link_clk_out(link_clk), .rail_out(rail_in),
        .now_out(now_r), .prev_out(prev_r)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up;
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : idle

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge mclk_in);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Rails after each launch edge, then unchanged across the other edge
    task automatic rails(input logic byp, input int n);
        dj_rail_t v;
        repeat (n)
        begin
            if (exp_edge)
                @(posedge link_clk);
            else
                @(negedge link_clk);
            #1;
            v = rail;
            check(v, byp ? now_r : prev_r);
            check(clk_o, link_clk);
            if (exp_edge)
                @(negedge link_clk);
            else
                @(posedge link_clk);
            #1;
            check(rail, v);
        end
        // Hand back on a system clock edge so pin changes follow it
        @(posedge mclk_in);
    endtask : rails

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        // Spans a rising link edge, so the link side reset is caught
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        apb(1'b0, DJ_CTRL_OFS, '0);
        check(rd, DJ_CTRL_RESET);
        for (int i = 0; i < 4; i++)
        begin
            edge_pin <= i[0];
            byp_pin <= i[1];
            exp_edge <= i[0];
            idle(60);
            rails(i[1], 6);
        end
        for (int i = 0; i < 4; i++)
        begin
            rate_pin <= i[0];
            addr <= i[1:0];
            idle(5);
            check(rate_o, i[0]);
            check(addr_o, i[1:0]);
            check(acc_o, 1'b0);
        end
        apb(1'b1, DJ_CTRL_OFS, 32'h7);
        check(err, 1'b1);
        apb(1'b0, DJ_CTRL_OFS, '0);
        check(rd, 32'h0);
        // Host mode with pins set against the register
        mode <= 1'b1;
        edge_pin <= 1'b0;
        byp_pin <= 1'b1;
        // Mode pin needs its synchroniser before a write is accepted
        idle(3);
        apb(1'b1, DJ_CTRL_OFS, 32'h3);
        check(err, 1'b0);
        exp_edge <= 1'b1;
        idle(60);
        apb(1'b0, DJ_STATUS_OFS, '0);
        check(rd, (32'h3 << DJ_STAT_ADDR_LSB) | (32'h1 << DJ_STAT_SEL_N_BIT)
                  | (32'h1 << DJ_STAT_HOST_BIT) | (32'h3 << DJ_STAT_EDGE_BIT));
        check(rate_o, 1'b1);
        rails(1'b0, 6);
        apb(1'b1, DJ_CTRL_OFS, 32'h4);
        exp_edge <= 1'b0;
        idle(60);
        check(rate_o, 1'b0);
        rails(1'b1, 6);
        // Serial select driven low for five system clock cycles
        rate_pin <= 1'b0;
        idle(5);
        check(acc_o, 1'b1);
        rate_pin <= 1'b1;
        idle(5);
        check(acc_o, 1'b0);
        apb(1'b0, 12'h008, '0);
        check(err, 1'b1);
        apb(1'b1, DJ_STATUS_OFS, 32'h1);
        check(err, 1'b1);
        apb(1'b0, DJ_CTRL_OFS, '0);
        check(rd, 32'h4);
        wrap_up();
    end

    // Whole run is well under 10 us
    initial
    begin
        #100us;
        failures++;
        wrap_up();
    end
endmodule : dj_port_top_test
`default_nettype wire
